// ==== monitor_pin_ctrl.sv ====
// pin-level control logic: resets, fan, over-temperature, general input, test mode
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module monitor_pin_ctrl
    import monitor_pin_pkg::*;
#(
    parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pad inputs, asynchronous
    input wire logic manual_reset_in_n,
    input wire logic supply_reset_io_n_in,
    input wire logic supply_low,
    input wire logic second_supply_monitor_low,
    input wire logic fan_speed_or_test_enable,
    input wire logic address_select_or_test_out_hi,
    input wire logic address_select_or_test_out_lo,
    input wire logic diode2_neg_or_overtemp_io_n_in,
    input wire logic diode2_pos_or_general_input,
    // pad drives
    output pin_drive_s fan_shutoff_n_pin,
    output pin_drive_s supply_reset_io_n_pin,
    output pin_drive_s combined_reset_out_n_pin,
    output pin_drive_s diode2_neg_or_overtemp_io_n_pin,
    output pin_drive_s alert_n_pin,
    output pin_drive_s address_select_or_test_out_pin,
    // on-chip events
    input wire logic fan_off_request,
    input wire logic temp_setpoint_violation,
    input wire logic trip_point_violation,
    // on-chip results
    output logic fan_full_on,
    output logic nand_test_mode,
    output logic device_reset_req,
    output logic [6:0] bus_address,
    output logic irq
);
    logic [NUM_SYNC-1:0] pad_in;
    logic [NUM_SYNC-1:0] sync1_reg;
    logic [NUM_SYNC-1:0] sync2_reg;
    logic mr_low;
    logic vcc_low;
    logic vmon_low;
    logic combined_cond;
    logic supply_active;
    logic combined_active;
    logic [ECHO_HOLDOFF_CYCLES-1:0] supply_hist_reg;
    logic [ECHO_HOLDOFF_CYCLES-1:0] overtemp_hist_reg;
    logic overtemp_drive_reg;
    logic supply_ext_low;
    logic overtemp_ext_low;
    logic gpi_active;
    logic fan_shutoff_reg;
    logic alert_drive_reg;
    logic test_out_reg;
    logic [CFG_W-1:0] config_reg;
    logic [STATUS_W-1:0] status_reg;
    logic [STATUS_W-1:0] status_next;
    logic [STATUS_W-1:0] mask_reg;
    logic [STATUS_W-1:0] events;
    logic [1:0] addr_low_reg;
    logic [1:0] addr_wait_reg;
    logic addr_done_reg;
    logic setup_phase;
    logic access;
    logic wr_en;
    logic rd_status;
    logic addr_ok;
    logic [31:0] rdata_next;

    assign pad_in = {diode2_pos_or_general_input, diode2_neg_or_overtemp_io_n_in,
                     address_select_or_test_out_lo, address_select_or_test_out_hi,
                     fan_speed_or_test_enable, second_supply_monitor_low, supply_low,
                     supply_reset_io_n_in, manual_reset_in_n};

    // two-stage synchroniser for every pad input
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SYNC; gi++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                // test pin resets to its idle level, else a false test entry follows reset
                if (!presetn)
                begin
                    sync1_reg[gi] <= (gi != IN_TEST);
                    sync2_reg[gi] <= (gi != IN_TEST);
                end
                else
                begin
                    sync1_reg[gi] <= pad_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    assign mr_low = !sync2_reg[IN_MR];
    assign vcc_low = sync2_reg[IN_VCC_LOW];
    assign vmon_low = sync2_reg[IN_VMON_LOW];
    assign combined_cond = mr_low || vcc_low || vmon_low;

    // both reset pins share one pulse count
    reset_stretch #(.PULSE_CYCLES(PULSE_CYCLES)) u_supply_stretch (
        .pclk(pclk),
        .presetn(presetn),
        .cond_in(vcc_low),
        .active_reg(supply_active)
    );

    reset_stretch #(.PULSE_CYCLES(PULSE_CYCLES)) u_combined_stretch (
        .pclk(pclk),
        .presetn(presetn),
        .cond_in(combined_cond),
        .active_reg(combined_active)
    );

    assign supply_reset_io_n_pin = '{out: 1'b0, oe_n: !supply_active};
    assign combined_reset_out_n_pin = '{out: 1'b0, oe_n: !combined_active};
    assign diode2_neg_or_overtemp_io_n_pin = '{out: 1'b0, oe_n: !overtemp_drive_reg};
    assign fan_shutoff_n_pin = '{out: 1'b0, oe_n: !fan_shutoff_reg};
    assign alert_n_pin = '{out: 1'b0, oe_n: !alert_drive_reg};
    assign address_select_or_test_out_pin = '{out: test_out_reg, oe_n: !nand_test_mode};

    // own drive echoes back through the synchroniser; ignore the pin until it settles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            supply_hist_reg <= '1;
            overtemp_hist_reg <= '0;
        end
        else
        begin
            supply_hist_reg <= {supply_hist_reg[ECHO_HOLDOFF_CYCLES-2:0], supply_active};
            overtemp_hist_reg <= {overtemp_hist_reg[ECHO_HOLDOFF_CYCLES-2:0], overtemp_drive_reg};
        end
    end

    assign supply_ext_low = !sync2_reg[IN_SUPPLY_IO] && !supply_active && supply_hist_reg == '0;
    assign overtemp_ext_low = config_reg[CFG_OVERTEMP_DIGITAL] && !sync2_reg[IN_OVERTEMP]
                              && !overtemp_drive_reg && overtemp_hist_reg == '0;
    assign gpi_active = config_reg[CFG_GPI_DIGITAL]
                        && (sync2_reg[IN_GPI] == config_reg[CFG_GPI_ACTIVE_HIGH]);

    // pin drives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fan_shutoff_reg <= 1'b0;
            overtemp_drive_reg <= 1'b0;
            alert_drive_reg <= 1'b0;
            fan_full_on <= 1'b0;
            device_reset_req <= 1'b0;
        end
        else
        begin
            fan_shutoff_reg <= fan_off_request;
            overtemp_drive_reg <= config_reg[CFG_OVERTEMP_DIGITAL] && temp_setpoint_violation;
            alert_drive_reg <= config_reg[CFG_INT_ENABLE] && trip_point_violation;
            fan_full_on <= overtemp_ext_low;
            device_reset_req <= supply_ext_low;
        end
    end

    // connectivity test: address pin shows nand of the other test inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nand_test_mode <= 1'b0;
            test_out_reg <= 1'b0;
        end
        else
        begin
            nand_test_mode <= sync2_reg[IN_TEST];
            test_out_reg <= !(sync2_reg[IN_MR] && sync2_reg[IN_OVERTEMP] && sync2_reg[IN_GPI]);
        end
    end

    // address low bits caught once, a few cycles after release so synchronisers are valid
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_wait_reg <= '0;
            addr_done_reg <= 1'b0;
            addr_low_reg <= ADDR_LOW_FLOAT;
        end
        else if (!addr_done_reg)
        begin
            if (addr_wait_reg == 2'(ADDR_SAMPLE_DELAY))
            begin
                addr_done_reg <= 1'b1;
                if (sync2_reg[IN_ADDR_HI])
                    addr_low_reg <= ADDR_LOW_VCC;
                else if (sync2_reg[IN_ADDR_LO])
                    addr_low_reg <= ADDR_LOW_GND;
                else
                    addr_low_reg <= ADDR_LOW_FLOAT;
            end
            else
                addr_wait_reg <= addr_wait_reg + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bus_address <= {BUS_ADDR_HIGH, ADDR_LOW_FLOAT};
        else
            bus_address <= {BUS_ADDR_HIGH, addr_low_reg};
    end

    // apb: one wait-free access phase, answer prepared in setup
    assign setup_phase = psel && !penable;
    assign access = psel && penable && pready;
    assign wr_en = access && pwrite;
    assign rd_status = access && !pwrite && paddr == ADDR_STATUS;
    assign addr_ok = paddr == ADDR_CONFIG || paddr == ADDR_STATUS || paddr == ADDR_MASK
                     || paddr == ADDR_PINS;

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        unique case (paddr)
            ADDR_CONFIG: rdata_next[CFG_W-1:0] = config_reg;
            ADDR_STATUS: rdata_next[STATUS_W-1:0] = status_reg;
            ADDR_MASK: rdata_next[STATUS_W-1:0] = mask_reg;
            ADDR_PINS:
            begin
                rdata_next[PINS_ADDR_LSB +: 2] = addr_low_reg;
                rdata_next[PINS_TEST] = nand_test_mode;
                rdata_next[PINS_SUPPLY_RST] = supply_active;
                rdata_next[PINS_COMBINED_RST] = combined_active;
                rdata_next[PINS_FAN_FULL] = fan_full_on;
            end
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup_phase;
            pslverr <= setup_phase && !addr_ok;
            prdata <= setup_phase ? rdata_next : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            config_reg <= CONFIG_RESET;
            mask_reg <= MASK_RESET;
        end
        else if (wr_en && paddr == ADDR_CONFIG)
            config_reg <= pwdata[CFG_W-1:0];
        else if (wr_en && paddr == ADDR_MASK)
            mask_reg <= pwdata[STATUS_W-1:0];
    end

    // sticky status: set beats clear; general input bit clears on read only
    always_comb
    begin
        events = '0;
        events[ST_SUPPLY_EXT] = supply_ext_low;
        events[ST_COMBINED_RST] = combined_active;
        events[ST_OVERTEMP_EXT] = overtemp_ext_low;
        events[ST_TRIP] = trip_point_violation;
        events[ST_GPI] = gpi_active;
        status_next = status_reg;
        if (wr_en && paddr == ADDR_STATUS)
            status_next[ST_TRIP:0] = status_reg[ST_TRIP:0] & ~pwdata[ST_TRIP:0];
        if (rd_status)
            status_next[ST_GPI] = 1'b0;
        status_next = status_next | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_reg <= STATUS_RESET;
            irq <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            irq <= |(status_next & mask_reg);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable && pready;
    endsequence

    a_apb_answer: assert property (s_setup ##1 psel && penable |-> pready)
        else $error("apb access not answered in one cycle");
    a_mr_resets: assert property (mr_low |=> !combined_reset_out_n_pin.oe_n)
        else $error("manual reset did not assert combined reset");
    a_vmon_resets: assert property (vmon_low |=> combined_active)
        else $error("second supply low did not assert combined reset");
    a_supply_holds: assert property (vcc_low |=> !supply_reset_io_n_pin.oe_n)
        else $error("supply reset pin released while supply low");
    a_supply_pulse: assert property ($fell(vcc_low) |=> supply_active [*2])
        else $error("supply reset not stretched");
    a_combined_pulse: assert property ($fell(combined_cond) |=> combined_active [*2])
        else $error("combined reset not stretched");
    a_fan_shutoff: assert property (fan_off_request |=> !fan_shutoff_n_pin.oe_n)
        else $error("fan shutoff not driven");
    a_overtemp_drive: assert property (config_reg[CFG_OVERTEMP_DIGITAL] && temp_setpoint_violation
                                       |=> !diode2_neg_or_overtemp_io_n_pin.oe_n)
        else $error("over-temperature pin not driven");
    a_ext_overtemp: assert property (overtemp_ext_low |=> fan_full_on && status_reg[ST_OVERTEMP_EXT])
        else $error("external over-temperature not acted on");
    a_alert_gate: assert property (!config_reg[CFG_INT_ENABLE] |=> alert_n_pin.oe_n)
        else $error("interrupt pin driven while disabled");
    a_gpi_sticky: assert property (status_reg[ST_GPI] && !(rd_status && !gpi_active)
                                   |=> status_reg[ST_GPI])
        else $error("general input status lost without read");
    a_gpi_read_clear: assert property (s_access ##0 rd_status && !gpi_active |=> !status_reg[ST_GPI])
        else $error("general input status not cleared by read");
    a_addr_frozen: assert property (addr_done_reg |-> ##2 $stable(bus_address))
        else $error("bus address changed after power-up");
    a_test_output: assert property (sync2_reg[IN_TEST] |=> !address_select_or_test_out_pin.oe_n)
        else $error("address pin not driven in test mode");
endmodule : monitor_pin_ctrl

// ==== reset_stretch.sv ====
// shared constants and types plus the reset pulse stretcher
`timescale 1ns/1ps
package monitor_pin_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_PINS = 8'h0C;
    // configuration fields
    localparam int CFG_W = 4;
    localparam int CFG_OVERTEMP_DIGITAL = 0;
    localparam int CFG_INT_ENABLE = 1;
    localparam int CFG_GPI_DIGITAL = 2;
    localparam int CFG_GPI_ACTIVE_HIGH = 3;
    localparam logic [CFG_W-1:0] CONFIG_RESET = 4'h0;
    // status and mask fields
    localparam int STATUS_W = 5;
    localparam int ST_SUPPLY_EXT = 0;
    localparam int ST_COMBINED_RST = 1;
    localparam int ST_OVERTEMP_EXT = 2;
    localparam int ST_TRIP = 3;
    localparam int ST_GPI = 4;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 5'h00;
    localparam logic [STATUS_W-1:0] MASK_RESET = 5'h00;
    // pin state register fields
    localparam int PINS_ADDR_LSB = 0;
    localparam int PINS_TEST = 2;
    localparam int PINS_SUPPLY_RST = 3;
    localparam int PINS_COMBINED_RST = 4;
    localparam int PINS_FAN_FULL = 5;
    // bus address: fixed high bits, low pair from the three-state pin
    localparam logic [4:0] BUS_ADDR_HIGH = 5'h0B;
    localparam logic [1:0] ADDR_LOW_FLOAT = 2'h0;
    localparam logic [1:0] ADDR_LOW_GND = 2'h2;
    localparam logic [1:0] ADDR_LOW_VCC = 2'h1;
    // synchronised pin indices
    localparam int IN_MR = 0;
    localparam int IN_SUPPLY_IO = 1;
    localparam int IN_VCC_LOW = 2;
    localparam int IN_VMON_LOW = 3;
    localparam int IN_TEST = 4;
    localparam int IN_ADDR_HI = 5;
    localparam int IN_ADDR_LO = 6;
    localparam int IN_OVERTEMP = 7;
    localparam int IN_GPI = 8;
    localparam int NUM_SYNC = 9;
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RESET_PULSE_TIME_NS = 200000;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int ECHO_HOLDOFF_CYCLES = 4;
    localparam int ADDR_SAMPLE_DELAY = 3;
    // one pad of the device: level driven and enable (low = driving)
    typedef struct packed {
        logic out;
        logic oe_n;
    } pin_drive_s;
endpackage : monitor_pin_pkg

module reset_stretch
    import monitor_pin_pkg::*;
#(
    parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // condition and stretched result
    input wire logic cond_in,
    output logic active_reg
);
    localparam int CW = $clog2(PULSE_CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(PULSE_CYCLES);

    logic [CW-1:0] count_reg;

    // reload while the condition stands, count down once it clears
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_reg <= '0;
        else if (cond_in)
            count_reg <= LOAD;
        else if (count_reg != '0)
            count_reg <= count_reg - 1'b1;
    end

    // active from reset so outputs start asserted
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            active_reg <= 1'b1;
        else
            active_reg <= cond_in || (count_reg != '0);
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_stretch_hold: assert property ($fell(cond_in) |-> ##1 active_reg [*2])
        else $error("reset released too early after condition cleared");
    a_stretch_release: assert property (!cond_in && count_reg == '0 |=> !active_reg)
        else $error("reset not released after pulse count");
endmodule : reset_stretch

// ==== monitor_pin_partner.sv ====
// system-side model: pull-ups, external pulldowns and auxiliary reset
`timescale 1ns/1ps
module monitor_pin_partner
    import monitor_pin_pkg::*;
(
    // device pad drives
    input wire pin_drive_s supply_drive,
    input wire pin_drive_s overtemp_drive,
    // pulldown requests from the system side
    input wire logic ext_supply_pull,
    input wire logic ext_overtemp_pull,
    // resolved wire levels
    output logic supply_level,
    output logic overtemp_level,
    output logic sys_aux_reset_n
);
    // open-drain wire: the pull-up wins unless someone sinks current
    function automatic logic od_level(input pin_drive_s d, input logic ext);
        return !(ext || (!d.oe_n && !d.out));
    endfunction : od_level

    assign supply_level = od_level(supply_drive, ext_supply_pull);
    assign overtemp_level = od_level(overtemp_drive, ext_overtemp_pull);
    // the external pulldown is masked so it never reaches the auxiliary reset
    assign sys_aux_reset_n = ext_supply_pull | supply_level;
endmodule : monitor_pin_partner

// ==== monitor_pin_control_logic_tb.sv ====
// self-checking bench for the pin control block
`timescale 1ns/1ps
module monitor_pin_control_logic_tb;
    import monitor_pin_pkg::*;
    localparam int P = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic mr_n = 1'b1, sup_low = 1'b0, vmon_low = 1'b0, test_en = 1'b0;
    logic add_hi = 1'b0, add_lo = 1'b0, gpi = 1'b0, fan_off = 1'b0;
    logic temp_viol = 1'b0, trip = 1'b0, ext_sup = 1'b0, ext_ot = 1'b0;
    pin_drive_s fan_pin, sup_pin, comb_pin, ot_pin, alert_pin, add_pin;
    logic fan_full_on, nand_test_mode, device_reset_req, irq;
    logic sup_level, ot_level;
    logic aux_n;
    logic [6:0] bus_address;
    logic [31:0] v;
    int fails = 0;
    int n_compared = 0;
    int seed = 32'h5ce9;

    monitor_pin_ctrl #(.PULSE_CYCLES(P)) u_monitor_pin_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .manual_reset_in_n(mr_n), .supply_reset_io_n_in(sup_level), .supply_low(sup_low),
        .second_supply_monitor_low(vmon_low), .fan_speed_or_test_enable(test_en),
        .address_select_or_test_out_hi(add_hi), .address_select_or_test_out_lo(add_lo),
        .diode2_neg_or_overtemp_io_n_in(ot_level), .diode2_pos_or_general_input(gpi), .fan_shutoff_n_pin(fan_pin),
        .supply_reset_io_n_pin(sup_pin), .combined_reset_out_n_pin(comb_pin), .diode2_neg_or_overtemp_io_n_pin(ot_pin),
        .alert_n_pin(alert_pin), .address_select_or_test_out_pin(add_pin), .fan_off_request(fan_off),
        .temp_setpoint_violation(temp_viol), .trip_point_violation(trip), .fan_full_on(fan_full_on),
        .nand_test_mode(nand_test_mode), .device_reset_req(device_reset_req), .bus_address(bus_address), .irq(irq));

    monitor_pin_partner u_monitor_pin_partner (.supply_drive(sup_pin), .overtemp_drive(ot_pin),
        .ext_supply_pull(ext_sup), .ext_overtemp_pull(ext_ot), .supply_level(sup_level),
        .overtemp_level(ot_level), .sys_aux_reset_n(aux_n));

    initial
    begin
        forever #2.5 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            fails++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        check("write error", 1'b0, err);
    endtask : wr

    task automatic rdm(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        check("read error", 1'b0, err);
        check(what, exp, rd & m);
    endtask : rdm

    task automatic cause(input int i, input logic on);
        case (i)
            0: mr_n <= !on;
            1: sup_low <= on;
            default: vmon_low <= on;
        endcase
    endtask : cause

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    // whole run is about three hundred cycles; this allows over sixty times that
    initial
    begin
        #100000;
        fails++;
        complete_run();
    end

    initial
    begin
        logic [31:0] rd;
        logic err;
        tick(12);
        presetn <= 1'b1;
        tick(P + 8);
        check("bus address", 7'h2C, bus_address);
        rdm("config", ADDR_CONFIG, 32'hFFFFFFFF, 32'h0);
        rdm("mask", ADDR_MASK, 32'hFFFFFFFF, 32'h0);
        rdm("pins", ADDR_PINS, 32'hFFFFFFFF, 32'h0);
        apb(1'b0, 8'h10, 32'h0, rd, err);
        check("unmapped error", 1'b1, err);
        check("unmapped data", 32'h0, rd);
        v = $random(seed);
        wr(ADDR_MASK, v);
        rdm("mask random", ADDR_MASK, 32'hFFFFFFFF, v & 32'h1F);
        wr(ADDR_MASK, 32'h0);
        add_lo <= 1'b1;
        tick(6);
        check("address kept", 7'h2C, bus_address);
        wr(ADDR_STATUS, 32'h0F);
        $display("register test done");
        for (int i = 0; i < 3; i++)
        begin
            cause(i, 1'b1);
            tick(5);
            check("combined", 1'b0, comb_pin.oe_n);
            check("supply", (i == 1) ? 1'b0 : 1'b1, sup_pin.oe_n);
            cause(i, 1'b0);
            tick(P);
            check("combined hold", 1'b0, comb_pin.oe_n);
            check("supply hold", (i == 1) ? 1'b0 : 1'b1, sup_pin.oe_n);
            tick(8);
            check("combined free", 1'b1, comb_pin.oe_n);
            check("supply free", 1'b1, sup_pin.oe_n);
            check("own echo", 1'b0, device_reset_req);
        end
        tick(6);
        ext_sup <= 1'b1;
        tick(5);
        check("external reset", 1'b1, device_reset_req);
        check("aux reset kept", 1'b1, aux_n);
        rdm("status supply", ADDR_STATUS, 32'h1, 32'h1);
        ext_sup <= 1'b0;
        tick(5);
        check("external reset off", 1'b0, device_reset_req);
        $display("reset test done");
        fan_off <= 1'b1;
        tick(2);
        check("fan off", 2'b00, fan_pin);
        fan_off <= 1'b0;
        tick(2);
        check("fan run", 1'b1, fan_pin.oe_n);
        wr(ADDR_CONFIG, 32'h0);
        trip <= 1'b1;
        tick(3);
        check("alert disabled", 1'b1, alert_pin.oe_n);
        check("irq masked", 1'b0, irq);
        wr(ADDR_MASK, 32'h8);
        tick(2);
        check("irq", 1'b1, irq);
        wr(ADDR_CONFIG, 32'h2);
        tick(2);
        check("alert", 2'b00, alert_pin);
        trip <= 1'b0;
        tick(2);
        check("alert off", 1'b1, alert_pin.oe_n);
        check("irq sticky", 1'b1, irq);
        wr(ADDR_STATUS, 32'h8);
        tick(2);
        check("irq cleared", 1'b0, irq);
        $display("interrupt test done");
        wr(ADDR_CONFIG, 32'h1);
        temp_viol <= 1'b1;
        tick(2);
        check("overtemp out", 2'b00, ot_pin);
        tick(3);
        check("own overtemp", 1'b0, fan_full_on);
        temp_viol <= 1'b0;
        tick(8);
        ext_ot <= 1'b1;
        tick(5);
        check("fan full", 1'b1, fan_full_on);
        rdm("status overtemp", ADDR_STATUS, 32'h4, 32'h4);
        ext_ot <= 1'b0;
        tick(5);
        check("fan full off", 1'b0, fan_full_on);
        $display("overtemp test done");
        for (int pol = 0; pol < 2; pol++)
        begin
            wr(ADDR_CONFIG, 32'h4 | (pol << 3));
            gpi <= pol[0];
            tick(5);
            rdm("gpi set", ADDR_STATUS, 32'h10, 32'h10);
            rdm("gpi held", ADDR_STATUS, 32'h10, 32'h10);
            gpi <= !pol[0];
            tick(5);
            wr(ADDR_STATUS, 32'h10);
            rdm("gpi sticky", ADDR_STATUS, 32'h10, 32'h10);
            rdm("gpi cleared", ADDR_STATUS, 32'h10, 32'h0);
        end
        $display("input test done");
        test_en <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            mr_n <= k[0];
            gpi <= k[1];
            tick(5);
            check("test mode", 1'b1, nand_test_mode);
            check("test out", {!(k[0] & k[1]), 1'b0}, add_pin);
        end
        test_en <= 1'b0;
        mr_n <= 1'b1;
        tick(5);
        check("test off", 1'b0, nand_test_mode);
        check("address released", 1'b1, add_pin.oe_n);
        check("address after test", 7'h2C, bus_address);
        $display("test mode done");
        add_lo <= 1'b0;
        add_hi <= 1'b1;
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        tick(2);
        check("supply after reset", 1'b0, sup_pin.oe_n);
        check("test after reset", 1'b0, nand_test_mode);
        tick(P + 6);
        check("address resampled", 7'h2D, bus_address);
        $display("second reset done");
        complete_run();
    end
endmodule : monitor_pin_control_logic_tb
